/* File: rtl/plc_rot_pkg.sv */
package plc_rot_pkg;
	// Command codes seen in the command word
	localparam logic [7:0] CMD_AUTO = 8'h00;
	localparam logic [7:0] CMD_SHOW = 8'h01;
	localparam logic [7:0] CMD_NEXT = 8'h02;
	localparam logic [7:0] CMD_CLEAR = 8'h03;
	localparam logic [7:0] CMD_ADD_GROSS = 8'h28;
	localparam logic [7:0] CMD_ADD_NET = 8'h29;
	localparam logic [7:0] CMD_ADD_RATE = 8'h2E;
	// Indication codes returned with each response
	localparam logic [7:0] IND_GROSS = 8'h00;
	localparam logic [7:0] IND_NET = 8'h01;
	localparam logic [7:0] IND_RATE = 8'h06;
	localparam logic [7:0] IND_NONE = 8'h1E;
	// Acknowledgment counts
	localparam logic [1:0] ACK_ZERO = 2'h0;
	localparam logic [1:0] ACK_ONE = 2'h1;
	localparam logic [1:0] ACK_TWO = 2'h2;
	localparam logic [1:0] ACK_MAX = 2'h3;
	// Value slot reset and config answer, 0.0 in single precision
	localparam logic [31:0] VALUE_ZERO = 32'h0000_0000;
	// Reset value of previous command sample, no real command uses it
	localparam logic [7:0] CMD_PREV_RST = 8'hFF;
	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned UPDATE_MS = 60;
	localparam int unsigned UPDATE_CYCLES = (UPDATE_MS * (CLK_HZ / 1000));
	// Transfer size: bytes per slot, slots per message, byte count width
	localparam int unsigned SLOT_BYTES = 4;
	localparam int unsigned MAX_SLOTS = 4;
	localparam int unsigned BYTES_W = 5;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_AUTO = 2'b01,
		MODE_MANUAL = 2'b10
	} mode_e;

	typedef enum logic [1:0] {
		FLD_GROSS = 2'b00,
		FLD_NET = 2'b01,
		FLD_RATE = 2'b10
	} field_e;
endpackage : plc_rot_pkg

/* File: rtl/update_timer.sv */
`timescale 1ns/1ps
module update_timer #(
	parameter int unsigned CYCLES = plc_rot_pkg::UPDATE_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	output logic tick_o
);
	localparam int unsigned CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] cnt_reg;
	logic tick_reg;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (cnt_reg == CNT_LAST) begin
				cnt_reg <= '0;
				tick_reg <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
				tick_reg <= 1'b0;
			end
		end
	end

	assign tick_o = tick_reg;
endmodule : update_timer

/* File: rtl/scale_plc_rotation.sv */
`timescale 1ns/1ps
module scale_plc_rotation #(
	parameter int unsigned UPDATE_CYCLES = plc_rot_pkg::UPDATE_CYCLES,
	parameter int unsigned ROT_DEPTH = 8,
	parameter int unsigned MSG_SLOTS = plc_rot_pkg::MAX_SLOTS
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic [7:0] cmd_word_i,
	input wire logic [31:0] gross_fp_i,
	input wire logic [31:0] net_fp_i,
	input wire logic [31:0] rate_fp_i,
	input wire logic fmt_div_i,
	input wire logic signed [15:0] weight_int_i,
	input wire logic signed [15:0] weight_div_i,
	output logic [1:0] ack_o,
	output logic [7:0] fp_ind_o,
	output logic [31:0] value_o,
	output logic signed [15:0] int_weight_o,
	output logic [plc_rot_pkg::BYTES_W-1:0] xfer_bytes_o,
	output logic update_o
);
	localparam int unsigned POS_W = (ROT_DEPTH > 1) ? $clog2(ROT_DEPTH) : 1;
	localparam int unsigned LEN_W = POS_W + 1;
	localparam logic [LEN_W-1:0] LEN_FULL = LEN_W'(ROT_DEPTH);
	localparam logic [plc_rot_pkg::BYTES_W-1:0] XFER_BYTES = plc_rot_pkg::BYTES_W'(MSG_SLOTS * plc_rot_pkg::SLOT_BYTES);

	logic tick;
	logic upd;
	logic [7:0] cmd_s1_reg;
	logic [7:0] cmd_s2_reg;
	logic [7:0] cmd_s3_reg;
	logic [7:0] cmd_now_reg;
	logic [7:0] cmd_prev_reg;
	logic new_cmd;
	plc_rot_pkg::mode_e mode_reg;
	plc_rot_pkg::mode_e mode_next;
	logic [POS_W-1:0] pos_reg;
	logic [POS_W-1:0] pos_next;
	logic [POS_W-1:0] pos_adv;
	logic [LEN_W-1:0] rot_len_reg;
	logic [LEN_W-1:0] rot_len_next;
	logic [1:0] ack_reg;
	logic [1:0] ack_next;
	logic [1:0] ack_cfg;
	logic add_en;
	plc_rot_pkg::field_e add_fld;
	logic report_field;
	plc_rot_pkg::field_e rot_mem [ROT_DEPTH];
	plc_rot_pkg::field_e cur_fld;
	logic [7:0] ind_reg;
	logic [31:0] value_reg;
	logic signed [15:0] int_reg;
	logic [plc_rot_pkg::BYTES_W-1:0] bytes_reg;

	update_timer #(
		.CYCLES(UPDATE_CYCLES)
	) u_update_timer (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i),
		.tick_o(tick)
	);

	assign upd = clk_en_i & tick;

	// Command word arrives from the link side, three stages
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_s1_reg <= plc_rot_pkg::CMD_AUTO;
			cmd_s2_reg <= plc_rot_pkg::CMD_AUTO;
			cmd_s3_reg <= plc_rot_pkg::CMD_AUTO;
			cmd_now_reg <= plc_rot_pkg::CMD_AUTO;
		end else if (clk_en_i) begin
			cmd_s1_reg <= cmd_word_i;
			cmd_s2_reg <= cmd_s1_reg;
			cmd_s3_reg <= cmd_s2_reg;
			// Only a settled word is taken, so a torn multi-bit change is never seen
			if (cmd_s2_reg == cmd_s3_reg) begin
				cmd_now_reg <= cmd_s3_reg;
			end
		end
	end

	// Sampled only at updates; reset value forces the first command to act
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_prev_reg <= plc_rot_pkg::CMD_PREV_RST;
		end else if (upd) begin
			cmd_prev_reg <= cmd_now_reg;
		end
	end

	assign new_cmd = (cmd_now_reg != cmd_prev_reg);

	always_comb begin
		if ((LEN_W'(pos_reg) + 1'b1) >= rot_len_reg) begin
			pos_adv = '0;
		end else begin
			pos_adv = pos_reg + 1'b1;
		end
		ack_cfg = ((ack_reg == plc_rot_pkg::ACK_MAX) || (ack_reg == plc_rot_pkg::ACK_ZERO)) ?
			plc_rot_pkg::ACK_ONE : ack_reg + 1'b1;
		mode_next = mode_reg;
		pos_next = pos_reg;
		rot_len_next = rot_len_reg;
		ack_next = ack_reg;
		add_en = 1'b0;
		add_fld = plc_rot_pkg::FLD_GROSS;
		report_field = 1'b0;
		if (new_cmd) begin
			case (cmd_now_reg)
				plc_rot_pkg::CMD_CLEAR: begin
					mode_next = plc_rot_pkg::MODE_IDLE;
					rot_len_next = '0;
					pos_next = '0;
					ack_next = plc_rot_pkg::ACK_ONE;
				end
				plc_rot_pkg::CMD_ADD_GROSS, plc_rot_pkg::CMD_ADD_NET, plc_rot_pkg::CMD_ADD_RATE: begin
					mode_next = plc_rot_pkg::MODE_IDLE;
					ack_next = ack_cfg;
					add_fld = (cmd_now_reg == plc_rot_pkg::CMD_ADD_NET) ? plc_rot_pkg::FLD_NET :
						(cmd_now_reg == plc_rot_pkg::CMD_ADD_RATE) ? plc_rot_pkg::FLD_RATE : plc_rot_pkg::FLD_GROSS;
					// A full table drops the append but still answers
					if (rot_len_reg != LEN_FULL) begin
						add_en = 1'b1;
						rot_len_next = rot_len_reg + 1'b1;
					end
				end
				plc_rot_pkg::CMD_AUTO: begin
					mode_next = plc_rot_pkg::MODE_AUTO;
					pos_next = '0;
					ack_next = plc_rot_pkg::ACK_ZERO;
					report_field = 1'b1;
				end
				plc_rot_pkg::CMD_SHOW, plc_rot_pkg::CMD_NEXT: begin
					mode_next = plc_rot_pkg::MODE_MANUAL;
					pos_next = (mode_reg == plc_rot_pkg::MODE_MANUAL) ? pos_adv : '0;
					ack_next = cmd_now_reg[1:0];
					report_field = 1'b1;
				end
				default: begin
					// Other commands belong elsewhere; rotation stops
					mode_next = plc_rot_pkg::MODE_IDLE;
					ack_next = ack_cfg;
				end
			endcase
		end else begin
			case (mode_reg)
				plc_rot_pkg::MODE_AUTO: begin
					pos_next = pos_adv;
					report_field = 1'b1;
				end
				plc_rot_pkg::MODE_MANUAL: begin
					report_field = 1'b1;
				end
				default: begin
					report_field = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_reg <= plc_rot_pkg::MODE_IDLE;
			pos_reg <= '0;
			rot_len_reg <= '0;
			ack_reg <= plc_rot_pkg::ACK_ZERO;
		end else if (upd) begin
			mode_reg <= mode_next;
			pos_reg <= pos_next;
			rot_len_reg <= rot_len_next;
			ack_reg <= ack_next;
		end
	end

	for (genvar g = 0; g < ROT_DEPTH; g++) begin : g_entry
		always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				rot_mem[g] <= plc_rot_pkg::FLD_GROSS;
			end else if (upd && add_en && (rot_len_reg == LEN_W'(g))) begin
				rot_mem[g] <= add_fld;
			end
		end
	end

	assign cur_fld = rot_mem[pos_next];

	// Response slot: empty rotation or config command answers 30 and 0.0
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ind_reg <= plc_rot_pkg::IND_NONE;
			value_reg <= plc_rot_pkg::VALUE_ZERO;
		end else if (upd) begin
			if (report_field && (rot_len_next != '0)) begin
				case (cur_fld)
					plc_rot_pkg::FLD_NET: begin
						ind_reg <= plc_rot_pkg::IND_NET;
						value_reg <= net_fp_i;
					end
					plc_rot_pkg::FLD_RATE: begin
						ind_reg <= plc_rot_pkg::IND_RATE;
						value_reg <= rate_fp_i;
					end
					default: begin
						ind_reg <= plc_rot_pkg::IND_GROSS;
						value_reg <= gross_fp_i;
					end
				endcase
			end else if (new_cmd) begin
				ind_reg <= plc_rot_pkg::IND_NONE;
				value_reg <= plc_rot_pkg::VALUE_ZERO;
			end
		end
	end

	// Integer and division formats, refreshed each update
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_reg <= '0;
			bytes_reg <= XFER_BYTES;
		end else if (upd) begin
			int_reg <= fmt_div_i ? weight_div_i : weight_int_i;
			bytes_reg <= XFER_BYTES;
		end
	end

	assign ack_o = ack_reg;
	assign fp_ind_o = ind_reg;
	assign value_o = value_reg;
	assign int_weight_o = int_reg;
	assign xfer_bytes_o = bytes_reg;
	assign update_o = upd;

	a_clear_answer: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && new_cmd && (cmd_now_reg == plc_rot_pkg::CMD_CLEAR) |=>
		(ack_o == plc_rot_pkg::ACK_ONE) && (fp_ind_o == plc_rot_pkg::IND_NONE) &&
		(value_o == plc_rot_pkg::VALUE_ZERO) && (rot_len_reg == '0))
		else $error("clear command answer wrong");

	a_add_net_answer: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && new_cmd && (cmd_now_reg == plc_rot_pkg::CMD_ADD_NET) && (rot_len_reg != LEN_FULL) |=>
		(rot_len_reg == $past(rot_len_reg) + 1'b1) && (fp_ind_o == plc_rot_pkg::IND_NONE) &&
		(rot_mem[$past(rot_len_reg[POS_W-1:0])] == plc_rot_pkg::FLD_NET))
		else $error("net append wrong");

	a_add_rate_ack: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && new_cmd && (cmd_now_reg == plc_rot_pkg::CMD_ADD_RATE) && (ack_reg == plc_rot_pkg::ACK_TWO) |=>
		(ack_o == plc_rot_pkg::ACK_MAX) && (value_o == plc_rot_pkg::VALUE_ZERO))
		else $error("rate append answer wrong");

	a_auto_rate_slot: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && !new_cmd && (mode_reg == plc_rot_pkg::MODE_AUTO) && (rot_len_reg != '0) &&
		(rot_mem[pos_adv] == plc_rot_pkg::FLD_RATE) |=>
		(fp_ind_o == plc_rot_pkg::IND_RATE) && (value_o == $past(rate_fp_i)) && (ack_o == plc_rot_pkg::ACK_ZERO))
		else $error("auto rate report wrong");

	a_auto_advance: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && !new_cmd && (mode_reg == plc_rot_pkg::MODE_AUTO) |=> (pos_reg == $past(pos_adv)))
		else $error("auto rotation did not advance");

	a_manual_net_refresh: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && !new_cmd && (mode_reg == plc_rot_pkg::MODE_MANUAL) && (rot_len_reg != '0) &&
		(rot_mem[pos_reg] == plc_rot_pkg::FLD_NET) |=>
		(fp_ind_o == plc_rot_pkg::IND_NET) && (value_o == $past(net_fp_i)))
		else $error("manual net refresh wrong");

	a_manual_next_step: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && new_cmd && (cmd_now_reg == plc_rot_pkg::CMD_NEXT) && (mode_reg == plc_rot_pkg::MODE_MANUAL) |=>
		(pos_reg == $past(pos_adv)) && (ack_o == plc_rot_pkg::ACK_TWO))
		else $error("next field command wrong");

	a_manual_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && !new_cmd && (mode_reg == plc_rot_pkg::MODE_MANUAL) |=> $stable(pos_reg) && $stable(ack_o))
		else $error("manual field moved without request");

	a_run_persists: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		upd && !new_cmd |=> (mode_reg == $past(mode_reg)))
		else $error("rotation mode changed without new command");

	a_quiet_between: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!upd |=> $stable(ack_o) && $stable(fp_ind_o) && $stable(value_o) && $stable(cmd_prev_reg))
		else $error("response changed between updates");
endmodule : scale_plc_rotation

/* File: bench/plc_model.sv */
`timescale 1ns/1ps
module plc_model (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic update_i,
	input wire logic [7:0] code_i,
	output logic [7:0] cmd_word_o
);
	// Word changes only on an update, so it is stable for the whole next period
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_word_o <= plc_rot_pkg::CMD_CLEAR;
		end else if (update_i) begin
			cmd_word_o <= code_i;
		end
	end
endmodule : plc_model

/* File: bench/tb_scale_plc_data_rotation.sv */
`timescale 1ns/1ps
module tb_scale_plc_data_rotation;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic [7:0] cmd_word_i;
	logic [7:0] next_code = 8'h03;
	logic [31:0] gross_fp_i = 32'h0000_0000;
	logic [31:0] net_fp_i = 32'h0000_0000;
	logic [31:0] rate_fp_i = 32'h0000_0000;
	logic fmt_div_i = 1'b0;
	logic signed [15:0] weight_int_i = 16'h0000;
	logic signed [15:0] weight_div_i = 16'h0000;
	logic [1:0] ack_o;
	logic [7:0] fp_ind_o;
	logic [31:0] value_o;
	logic signed [15:0] int_weight_o;
	logic [plc_rot_pkg::BYTES_W-1:0] xfer_bytes_o;
	logic update_o;
	logic [31:0] seed = 32'h7a8c;
	logic [31:0] e_ack, e_ind, e_val, e_int;
	int fails = 0;
	int checks = 0;
	int rot[$];
	int mode, idx, prv, a, f;
	bit chk = 0;
	// Short period keeps the run brief; model follows the pulse, not the count
	scale_plc_rotation #(.UPDATE_CYCLES(16)) DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i), .cmd_word_i(cmd_word_i), .gross_fp_i(gross_fp_i), .net_fp_i(net_fp_i),
		.rate_fp_i(rate_fp_i), .fmt_div_i(fmt_div_i), .weight_int_i(weight_int_i),
		.weight_div_i(weight_div_i), .ack_o(ack_o), .fp_ind_o(fp_ind_o), .value_o(value_o),
		.int_weight_o(int_weight_o), .xfer_bytes_o(xfer_bytes_o), .update_o(update_o));
	plc_model plc (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .update_i(update_o),
		.code_i(next_code), .cmd_word_o(cmd_word_i));
	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	always @(posedge sys_clk_i) begin
		seed = xs(seed);
		gross_fp_i <= seed;
		net_fp_i <= {seed[15:0], seed[31:16]};
		rate_fp_i <= ~seed;
		weight_int_i <= seed[15:0];
		weight_div_i <= seed[31:16];
		fmt_div_i <= seed[7];
		// Rare enable drops, so the freeze path runs without starving the update timer
		clk_en_i <= (seed[11:8] != 4'h0);
	end
	function automatic int nxt();
		return (rot.size() > 0) ? (idx + 1) % rot.size() : 0;
	endfunction : nxt
	// Reference model, sees the same pre-edge inputs as the design at an update
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			rot.delete();
			mode = 0;
			idx = 0;
			prv = 255;
			a = 0;
		end else if (update_o === 1'b1) begin
			if (cmd_word_i != prv) begin
				case (cmd_word_i)
					8'h03: begin
						rot.delete();
						mode = 0;
						a = 1;
					end
					8'h28, 8'h29, 8'h2E: begin
						if (rot.size() < 8) begin
							rot.push_back(cmd_word_i == 8'h28 ? 0 : cmd_word_i == 8'h29 ? 1 : 2);
						end
						mode = 0;
						a = (a == 0 || a == 3) ? 1 : a + 1;
					end
					8'h00: begin
						mode = 1;
						idx = 0;
						a = 0;
					end
					8'h01, 8'h02: begin
						idx = (mode == 2) ? nxt() : 0;
						mode = 2;
						a = cmd_word_i;
					end
					// Unknown codes stop the rotation and count like a config answer
					default: begin
						mode = 0;
						a = (a == 0 || a == 3) ? 1 : a + 1;
					end
				endcase
				prv = cmd_word_i;
			end else if (mode == 1) begin
				idx = nxt();
			end
			e_ind = 30;
			e_val = 0;
			if (mode != 0 && rot.size() > 0) begin
				f = rot[idx];
				e_ind = (f == 0) ? 0 : (f == 1) ? 1 : 6;
				e_val = (f == 0) ? gross_fp_i : (f == 1) ? net_fp_i : rate_fp_i;
			end
			e_ack = a;
			e_int = fmt_div_i ? {{16{weight_div_i[15]}}, weight_div_i} : {{16{weight_int_i[15]}}, weight_int_i};
			chk = 1;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	always @(negedge sys_clk_i) begin
		if (chk) begin
			chk = 0;
			check({30'h0000_0000, ack_o}, e_ack);
			check({24'h00_0000, fp_ind_o}, e_ind);
			check(value_o, e_val);
			check({{16{int_weight_o[15]}}, int_weight_o}, e_int);
			check({27'h000_0000, xfer_bytes_o}, 32'h0000_0010);
		end
	end
	task automatic summarize();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// Bounded wait for n update pulses
	task automatic updates(input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			@(posedge sys_clk_i);
			while (update_o !== 1'b1) begin
				t++;
				if (t > 80) begin
					fails++;
					summarize();
				end
				@(posedge sys_clk_i);
			end
		end
	endtask : updates
	// Second half fills the table past its depth, then one unknown code stops the rotation
	logic [7:0] codes[26] = '{8'h03, 8'h29, 8'h2E, 8'h00, 8'h01, 8'h02, 8'h01, 8'h02, 8'h7F, 8'h03, 8'h28,
		8'h2E, 8'h00, 8'h01, 8'h03, 8'h28, 8'h29, 8'h28, 8'h29, 8'h28, 8'h29, 8'h28, 8'h2E, 8'h29,
		8'h00, 8'h7F};
	int holds[26] = '{2, 2, 2, 5, 4, 3, 2, 2, 2, 2, 2, 2, 4, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 10, 3};
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 26; i++) begin
			if (i == 14) begin
				// Mid-run reset, one edge after an update so its check has already run
				@(posedge sys_clk_i);
				rst_b_i <= 1'b0;
				@(negedge sys_clk_i);
				check({24'h00_0000, fp_ind_o}, 32'h0000_001E);
				check(value_o, 32'h0000_0000);
				check({27'h000_0000, xfer_bytes_o}, 32'h0000_0010);
				repeat (3) @(posedge sys_clk_i);
				rst_b_i <= 1'b1;
			end
			next_code <= codes[i];
			updates(holds[i]);
			$display("test command %h done", codes[i]);
		end
		summarize();
	end
endmodule : tb_scale_plc_data_rotation
